// *** rtl/wakeup_pkg.sv ***
// Constants, register map and divide table for the periodic wakeup counter.
package wakeup_pkg;

    // Bus, register and divide ratio widths.
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int REG_W = 8;
    localparam int RATIO_W = 18;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] OFF_STATUS_CONTROL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_CURRENT_COUNT = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_MATCH_LIMIT = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h010;

    // Field positions in the status/control register.
    localparam int FLAG_BIT = 7;
    localparam int SRC_HI = 6;
    localparam int SRC_LO = 5;
    localparam int IRQ_EN_BIT = 4;
    localparam int PS_HI = 3;
    localparam int PS_LO = 0;
    // Bit position of the event in the interrupt status and mask registers.
    localparam int IRQ_BIT = 0;

    // Reset values.
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam logic [3:0] PS_RESET = 4'h0;
    localparam logic [REG_W-1:0] LIMIT_RESET = 8'h00;
    localparam logic [REG_W-1:0] COUNT_RESET = 8'h00;

    // Source select codes, prescaler off code and source indices.
    localparam logic [1:0] SRC_LPO = 2'h0;
    localparam logic [3:0] PS_OFF = 4'h0;
    localparam int N_SOURCES = 3;
    localparam logic [1:0] IDX_LPO = 2'h0;
    localparam logic [1:0] IDX_EXT = 2'h1;
    localparam logic [1:0] IDX_INT = 2'h2;

    // Bus answer states.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_t;

    // Divide ratio for a bank (low source bit) and prescale code; 0 is off.
    function automatic logic [RATIO_W-1:0] divideRatio(
        input logic bank,
        input logic [3:0] sel
    );
        logic [RATIO_W-1:0] r;
        case ({bank, sel})
            5'h01: r = 18'h00008;
            5'h02: r = 18'h00020;
            5'h03: r = 18'h00040;
            5'h04: r = 18'h00080;
            5'h05: r = 18'h00100;
            5'h06: r = 18'h00200;
            5'h07: r = 18'h00400;
            5'h08: r = 18'h00001;
            5'h09: r = 18'h00002;
            5'h0A: r = 18'h00004;
            5'h0B: r = 18'h0000A;
            5'h0C: r = 18'h00010;
            5'h0D: r = 18'h00064;
            5'h0E: r = 18'h001F4;
            5'h0F: r = 18'h003E8;
            5'h11: r = 18'h00400;
            5'h12: r = 18'h00800;
            5'h13: r = 18'h01000;
            5'h14: r = 18'h02000;
            5'h15: r = 18'h04000;
            5'h16: r = 18'h08000;
            5'h17: r = 18'h10000;
            5'h18: r = 18'h003E8;
            5'h19: r = 18'h007D0;
            5'h1A: r = 18'h01388;
            5'h1B: r = 18'h02710;
            5'h1C: r = 18'h04E20;
            5'h1D: r = 18'h0C350;
            5'h1E: r = 18'h186A0;
            5'h1F: r = 18'h30D40;
            default: r = 18'h00000;
        endcase
        return r;
    endfunction

endpackage

// *** rtl/prescale_divider.sv ***
// Prescaler that turns source ticks into one pulse per ratio ticks.
`timescale 1ns/1ps
module prescale_divider #(
    parameter int RATIO_W = 18
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // Control.
    input wire logic clear,
    input wire logic [RATIO_W-1:0] ratio,
    input wire logic tickIn,
    // Output pulse.
    output logic pulseOut
);

    logic [RATIO_W-1:0] count_q;
    logic pulse_q;

    // Counts source ticks; a zero ratio holds the divider stopped at zero.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
            pulse_q <= 1'b0;
        end else if (clear || ratio == '0) begin
            count_q <= '0;
            pulse_q <= 1'b0;
        end else if (tickIn) begin
            if (count_q >= ratio - RATIO_W'(1)) begin
                count_q <= '0;
                pulse_q <= 1'b1;
            end else begin
                count_q <= count_q + RATIO_W'(1);
                pulse_q <= 1'b0;
            end
        end else begin
            pulse_q <= 1'b0;
        end
    end

    assign pulseOut = pulse_q;

endmodule

// *** rtl/periodic_wakeup_counter.sv ***
// Periodic wakeup counter with prescaler, modulo match and APB registers.
//
// Behaviour
// - Eight-bit up-counter compared to a modulo limit; a match is one event.
// - Counter keeps running in wait mode; its interrupt can end wait.
// - Counter keeps running in both retained stop modes; interrupt wakes.
// - Low-power source works in both stops; reference sources only shallow.
// - Debug mode freezes counting; resumes from held value unless reset.
// - Match flag sits in bit 7; writing one clears it, zero does nothing.
// - Bits 6-5 pick the source: 00 low-power, 01 external, 1x internal.
// - Changing the source clears prescaler and counter.
// - Bit 4 enables the interrupt; without it software polls the flag.
// - Bits 3-0 pick the divide ratio; a change clears both counters.
// - Low source bit zero: off, 8..1024 binary, then 1..1000 decimal.
// - Low source bit one: off, 2^10..2^16, then 1000..200000 decimal.
// - Count register reads the counter; writes to it are ignored.
// - Counter clears on reset, limit write, or changed source/prescale.
// - Reset clears flag, source, enable and prescale; prescaler stopped.
// - Counter steps per prescaler pulse up to the limit, then wraps.
// - Flag sets on the wrap to zero; limit zero sets it every pulse.
// - Limit register is read/write, resets to zero, a write clears counters.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module periodic_wakeup_counter
    import wakeup_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Source clocks, sampled as levels.
    input wire logic lowPowerOscClk,
    input wire logic extRefClk,
    input wire logic intRefClk,
    // Processor mode.
    input wire logic stopDeepMode,
    input wire logic debugActive,
    // Interrupt and wakeup request.
    output logic irqOut
);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // Address match used by every register decode.
    function automatic logic isOffset(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] off
    );
        return addr == off;
    endfunction

    bus_state_t busState_q;
    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] readValue;
    logic pready_q;
    logic pslverr_q;
    logic irqOut_q;
    logic mapped;
    logic writeCommit;
    logic wrStatus;
    logic wrLimit;
    logic wrIrqStatus;
    logic wrIrqMask;
    logic srcChanged;
    logic psChanged;
    logic clearCounters;
    logic flagClear;
    logic matchEvent;
    logic matchFlag_q;
    logic matchIrqEnable_q;
    logic [1:0] sourceSelect_q;
    logic [3:0] prescaleSelect_q;
    logic [REG_W-1:0] matchLimit_q;
    logic [REG_W-1:0] currentCount_q;
    logic [N_SOURCES-1:0] srcLevel;
    logic [N_SOURCES-1:0] srcSample_q;
    logic [N_SOURCES-1:0] srcPrev_q;
    logic [N_SOURCES-1:0] srcRise;
    logic [1:0] srcIdx;
    logic sourceUsable;
    logic tick;
    logic prescPulse;
    logic [RATIO_W-1:0] ratio;

    // Any decoded register address.
    assign mapped = isOffset(paddr, OFF_STATUS_CONTROL)
        || isOffset(paddr, OFF_CURRENT_COUNT)
        || isOffset(paddr, OFF_MATCH_LIMIT)
        || isOffset(paddr, OFF_IRQ_STATUS)
        || isOffset(paddr, OFF_IRQ_MASK);

    // A write takes effect on the edge where the master samples pready.
    assign writeCommit = (busState_q == BUS_DONE) && psel && penable && pwrite;
    assign wrStatus = writeCommit && isOffset(paddr, OFF_STATUS_CONTROL);
    assign wrLimit = writeCommit && isOffset(paddr, OFF_MATCH_LIMIT);
    assign wrIrqStatus = writeCommit && isOffset(paddr, OFF_IRQ_STATUS);
    assign wrIrqMask = writeCommit && isOffset(paddr, OFF_IRQ_MASK);

    assign srcChanged = wrStatus
        && (pwdata[SRC_HI:SRC_LO] != sourceSelect_q);
    assign psChanged = wrStatus && (pwdata[PS_HI:PS_LO] != prescaleSelect_q);
    assign clearCounters = wrLimit || srcChanged || psChanged;

    // Read multiplexer; the count register is read-only.
    always_comb begin
        readValue = '0;
        if (isOffset(paddr, OFF_STATUS_CONTROL)) begin
            readValue[FLAG_BIT] = matchFlag_q;
            readValue[SRC_HI:SRC_LO] = sourceSelect_q;
            readValue[IRQ_EN_BIT] = matchIrqEnable_q;
            readValue[PS_HI:PS_LO] = prescaleSelect_q;
        end else if (isOffset(paddr, OFF_CURRENT_COUNT)) begin
            readValue[REG_W-1:0] = currentCount_q;
        end else if (isOffset(paddr, OFF_MATCH_LIMIT)) begin
            readValue[REG_W-1:0] = matchLimit_q;
        end else if (isOffset(paddr, OFF_IRQ_STATUS)) begin
            readValue[IRQ_BIT] = matchFlag_q;
        end else if (isOffset(paddr, OFF_IRQ_MASK)) begin
            readValue[IRQ_BIT] = matchIrqEnable_q;
        end
    end

    // Answers each access one cycle after penable rises, from flip-flops.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busState_q <= BUS_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            case (busState_q)
                BUS_IDLE: begin
                    if (psel && penable) begin
                        busState_q <= BUS_DONE;
                        pready_q <= 1'b1;
                        pslverr_q <= !mapped;
                        prdata_q <= pwrite ? '0 : readValue;
                    end
                end
                BUS_DONE: begin
                    busState_q <= BUS_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                    prdata_q <= '0;
                end
                default: begin
                    busState_q <= BUS_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                    prdata_q <= '0;
                end
            endcase
        end
    end

    // Control fields; the mask register aliases the enable bit.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sourceSelect_q <= SRC_RESET;
            prescaleSelect_q <= PS_RESET;
            matchIrqEnable_q <= 1'b0;
        end else if (wrStatus) begin
            sourceSelect_q <= pwdata[SRC_HI:SRC_LO];
            prescaleSelect_q <= pwdata[PS_HI:PS_LO];
            matchIrqEnable_q <= pwdata[IRQ_EN_BIT];
        end else if (wrIrqMask) begin
            matchIrqEnable_q <= pwdata[IRQ_BIT];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            matchLimit_q <= LIMIT_RESET;
        end else if (wrLimit) begin
            matchLimit_q <= pwdata[REG_W-1:0];
        end
    end

    // Samples every source level and keeps the previous value for edges.
    assign srcLevel = {intRefClk, extRefClk, lowPowerOscClk};
    generate
        for (genvar i = 0; i < N_SOURCES; i++) begin : gSrc
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    srcSample_q[i] <= 1'b0;
                    srcPrev_q[i] <= 1'b0;
                end else begin
                    srcSample_q[i] <= srcLevel[i];
                    srcPrev_q[i] <= srcSample_q[i];
                end
            end
            assign srcRise[i] = srcSample_q[i] && !srcPrev_q[i];
        end
    endgenerate

    assign srcIdx = sourceSelect_q[1] ? IDX_INT
        : (sourceSelect_q[0] ? IDX_EXT : IDX_LPO);
    // reference sources halt in deep stop.
    assign sourceUsable = !stopDeepMode || (srcIdx == IDX_LPO);
    assign tick = srcRise[srcIdx] && sourceUsable && !debugActive;
    assign ratio = divideRatio(sourceSelect_q[0], prescaleSelect_q);

    prescale_divider #(
        .RATIO_W(RATIO_W)
    ) uDivider (
        .clock(clock),
        .reset_n(reset_n),
        .clear(clearCounters),
        .ratio(ratio),
        .tickIn(tick),
        .pulseOut(prescPulse)
    );

    assign matchEvent = prescPulse && !clearCounters
        && (currentCount_q == matchLimit_q);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            currentCount_q <= COUNT_RESET;
        end else if (clearCounters) begin
            currentCount_q <= COUNT_RESET;
        end else if (prescPulse) begin
            if (currentCount_q == matchLimit_q) begin
                currentCount_q <= COUNT_RESET;
            end else begin
                currentCount_q <= currentCount_q + 8'h01;
            end
        end
    end

    assign flagClear = (wrStatus && pwdata[FLAG_BIT])
        || (wrIrqStatus && pwdata[IRQ_BIT]);

    // Sticky flag; a match in the clearing cycle keeps it set.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            matchFlag_q <= 1'b0;
        end else if (matchEvent) begin
            matchFlag_q <= 1'b1;
        end else if (flagClear) begin
            matchFlag_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irqOut_q <= 1'b0;
        end else begin
            irqOut_q <= matchFlag_q && matchIrqEnable_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irqOut = irqOut_q;

    // Steps of an access and of a debug freeze.
    sequence accessStart;
        psel && penable && !pready_q;
    endsequence
    sequence frozen;
        debugActive [*3];
    endsequence

    chk_bus_answer: assert property (
        accessStart |=> pready_q ##1 !pready_q)
        else $error("bus answer not one cycle after access");
    chk_count_wrap: assert property (
        matchEvent |=> currentCount_q == COUNT_RESET)
        else $error("counter did not wrap at the limit");
    chk_count_step: assert property (
        prescPulse && !clearCounters && currentCount_q != matchLimit_q
        |=> currentCount_q == $past(currentCount_q) + 8'h01)
        else $error("counter did not step by one");
    chk_flag_set: assert property (
        matchEvent |=> matchFlag_q [*2] or (matchFlag_q ##1 1'b1))
        else $error("match flag not set on wrap");
    chk_flag_clear: assert property (
        wrStatus && pwdata[FLAG_BIT] && !matchEvent |=> !matchFlag_q)
        else $error("write of one did not clear flag");
    chk_flag_keep: assert property (
        wrStatus && !pwdata[FLAG_BIT] && matchFlag_q |=> matchFlag_q)
        else $error("write of zero cleared flag");
    chk_irq_level: assert property (
        matchFlag_q && matchIrqEnable_q ##1 matchFlag_q && matchIrqEnable_q
        |-> irqOut_q)
        else $error("interrupt low while flag and enable set");
    chk_irq_gate: assert property (
        !matchIrqEnable_q [*2] |-> !irqOut_q)
        else $error("interrupt high while disabled");
    chk_clear_counters: assert property (
        clearCounters |=> currentCount_q == COUNT_RESET && !prescPulse)
        else $error("counters not cleared by a reload write");
    chk_limit_write: assert property (
        wrLimit |=> matchLimit_q == $past(pwdata[REG_W-1:0]))
        else $error("limit register not written");
    chk_debug_freeze: assert property (
        frozen ##0 !$past(clearCounters) |-> $stable(currentCount_q))
        else $error("counter moved during debug");
    chk_deep_stop: assert property (
        stopDeepMode && srcIdx != IDX_LPO |-> !tick)
        else $error("reference source ticked in deep stop");
    chk_prescale_off: assert property (
        prescaleSelect_q == PS_OFF [*2] |-> !prescPulse)
        else $error("prescaler ran while off");
    chk_count_readonly: assert property (
        writeCommit && isOffset(paddr, OFF_CURRENT_COUNT) && !prescPulse
        |=> currentCount_q == $past(currentCount_q))
        else $error("count register took a write");
    chk_source_clear: assert property (
        srcChanged |=> currentCount_q == COUNT_RESET && !prescPulse)
        else $error("source change did not clear counters");
    chk_limit_clear: assert property (
        wrLimit |=> currentCount_q == COUNT_RESET && !prescPulse)
        else $error("limit write did not clear counters");
    chk_flag_hold: assert property (
        matchFlag_q && !flagClear |=> matchFlag_q)
        else $error("match flag dropped without a clear");
    chk_irq_drop: assert property (
        !matchFlag_q |=> !irqOut_q)
        else $error("interrupt high without the flag");

endmodule

// *** verif/test_periodic_wakeup_counter.sv ***
// Self-checking testbench for the periodic wakeup counter.
`timescale 1ns/1ps
module test_periodic_wakeup_counter;
    import wakeup_pkg::*;

    // Design connections.
    logic clock;
    logic reset_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] srcClk;
    logic stopDeepMode;
    logic debugActive;
    logic irqOut;
    logic [DATA_W-1:0] q;
    logic err;
    // Bench bookkeeping.
    int n_errors;
    int compares;
    int cycles;
    // Reference model state.
    int mCount;
    int mDiv;
    int mLimit;
    int mSrc;
    int mPs;
    int mFlag;
    int mIe;
    int r0[16] = '{0, 8, 32, 64, 128, 256, 512, 1024,
        1, 2, 4, 10, 16, 100, 500, 1000};
    int r1[16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536,
        1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};

    // Device under test.
    periodic_wakeup_counter i_dut (
        .clock(clock),
        .reset_n(reset_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .lowPowerOscClk(srcClk[0]),
        .extRefClk(srcClk[1]),
        .intRefClk(srcClk[2]),
        .stopDeepMode(stopDeepMode),
        .debugActive(debugActive),
        .irqOut(irqOut)
    );

    // Free-running system clock.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("Errors %0d, comparisons %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 100000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // Compares a seen value with the expected one.
    task automatic check(input logic [DATA_W-1:0] seen,
            input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    // One APB transfer; waits for pready with no assumed latency.
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rq,
            output logic re);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register write that also updates the reference model.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [DATA_W-1:0] rq;
        logic re;
        apb(1'b1, a, {24'h000000, d}, rq, re);
        if (a == OFF_STATUS_CONTROL) begin
            if (int'(d[6:5]) != mSrc || int'(d[3:0]) != mPs) begin
                mCount = 0;
                mDiv = 0;
            end
            mSrc = d[6:5];
            mPs = d[3:0];
            mIe = d[4];
            if (d[7])
                mFlag = 0;
        end else if (a == OFF_MATCH_LIMIT) begin
            mLimit = d;
            mCount = 0;
            mDiv = 0;
        end else if (a == OFF_IRQ_STATUS && d[0]) begin
            mFlag = 0;
        end else if (a == OFF_IRQ_MASK) begin
            mIe = d[0];
        end
    endtask

    // Register read compared with an expected word.
    task automatic rd(input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] rq;
        logic re;
        apb(1'b0, a, 32'h00000000, rq, re);
        check(rq, exp);
        check({31'h00000000, re}, 32'h00000000);
    endtask

    // Expected status/control byte from the model.
    function automatic logic [7:0] stat();
        return {mFlag[0], mSrc[1:0], mIe[0], mPs[3:0]};
    endfunction

    // Source line that the selected clock source drives.
    function automatic int srcIdx();
        return (mSrc == 0) ? 0 : (mSrc == 1) ? 1 : 2;
    endfunction

    // One source edge as seen by the model.
    task automatic tick();
        int r;
        r = (mSrc % 2 == 0) ? r0[mPs] : r1[mPs];
        if (r == 0)
            return;
        mDiv++;
        if (mDiv == r) begin
            mDiv = 0;
            if (mCount == mLimit) begin
                mCount = 0;
                mFlag = 1;
            end else begin
                mCount++;
            end
        end
    endtask

    // Slow pulses on one source line, then time for the count to settle.
    task automatic pulses(input int idx, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            srcClk[idx] <= 1'b1;
            repeat (3) @(posedge clock);
            srcClk[idx] <= 1'b0;
            repeat (2) @(posedge clock);
            if (idx == srcIdx() && debugActive == 1'b0 &&
                    !(stopDeepMode == 1'b1 && idx != 0))
                tick();
        end
        repeat (8) @(posedge clock);
    endtask

    // Reads status, count and flag alias and checks the interrupt level.
    task automatic verify();
        rd(OFF_STATUS_CONTROL, {24'h000000, stat()});
        rd(OFF_CURRENT_COUNT, mCount);
        rd(OFF_IRQ_STATUS, mFlag);
        check({31'h00000000, irqOut}, mFlag & mIe);
    endtask

    // Main sequence.
    initial begin
        int r;
        void'($urandom(56667));
        n_errors = 0;
        compares = 0;
        cycles = 0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        srcClk = 3'h0;
        stopDeepMode = 1'b0;
        debugActive = 1'b0;
        {mCount, mDiv, mLimit, mSrc, mPs, mFlag, mIe} = '0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        verify();
        rd(OFF_MATCH_LIMIT, 32'h00000000);
        rd(OFF_IRQ_MASK, 32'h00000000);
        apb(1'b1, 12'h014, 32'h000000FF, q, err);
        check({31'h00000000, err}, 32'h00000001);
        pulses(0, 3);
        verify();
        wr(OFF_CURRENT_COUNT, 8'h55);
        rd(OFF_CURRENT_COUNT, 32'h00000000);
        wr(OFF_MATCH_LIMIT, 8'hA5);
        rd(OFF_MATCH_LIMIT, 32'h000000A5);
        wr(OFF_MATCH_LIMIT, 8'h03);
        wr(OFF_STATUS_CONTROL, 8'h18);
        pulses(0, 2);
        verify();
        pulses(0, 2);
        verify();
        wr(OFF_STATUS_CONTROL, 8'h18);
        verify();
        wr(OFF_IRQ_MASK, 8'h00);
        verify();
        wr(OFF_IRQ_MASK, 8'h01);
        verify();
        wr(OFF_STATUS_CONTROL, 8'h98);
        verify();
        pulses(1, 2);
        pulses(2, 2);
        verify();
        wr(OFF_MATCH_LIMIT, 8'h00);
        pulses(0, 1);
        verify();
        wr(OFF_IRQ_STATUS, 8'h01);
        verify();
        wr(OFF_STATUS_CONTROL, 8'h98);
        wr(OFF_MATCH_LIMIT, 8'h10);
        pulses(0, 3);
        debugActive <= 1'b1;
        pulses(0, 4);
        verify();
        debugActive <= 1'b0;
        pulses(0, 2);
        verify();
        stopDeepMode <= 1'b1;
        pulses(0, 2);
        verify();
        wr(OFF_STATUS_CONTROL, 8'h48);
        verify();
        pulses(2, 3);
        verify();
        stopDeepMode <= 1'b0;
        pulses(2, 3);
        verify();
        wr(OFF_STATUS_CONTROL, 8'h29);
        verify();
        wr(OFF_MATCH_LIMIT, 8'hFF);
        for (int s = 0; s < 4; s++) begin
            for (int p = 1; p < 16; p++) begin
                r = (s % 2 == 0) ? r0[p] : r1[p];
                if (r > 1100)
                    continue;
                wr(OFF_STATUS_CONTROL, {1'b0, 2'(s), 1'b0, 4'(p)});
                pulses(srcIdx(), $urandom_range(r + 3, 1));
                verify();
            end
        end
        wr(OFF_STATUS_CONTROL, 8'h80);
        verify();
        report_and_stop();
    end

endmodule
